/* hw/rdb_pkg.sv */
// Constants and types for the rally error display and brightness control
package rdb_pkg;
  // Register port offsets
  localparam logic [3:0] REG_FMT = 4'h0;
  localparam logic [3:0] REG_LVL = 4'h4;
  localparam logic [3:0] REG_ERR = 4'h8;
  // Error format bit positions and reset value, brightness level maximum and reset value
  localparam int FMT_SEC = 0;
  localparam int FMT_CDN = 1;
  localparam int FMT_TEN = 2;
  localparam logic [2:0] FMT_RST = 3'h0;
  localparam logic [4:0] LVL_MAX = 5'h1F;
  localparam logic [4:0] LVL_RST = 5'h1F;
  // Switch codes
  localparam logic [3:0] ROT_SPECIAL = 4'h0;
  localparam logic [3:0] ROT_NEXT_SPD = 4'h1;
  localparam logic [1:0] SEL_DELTA = 2'h1;
  // Timing
  localparam int CLK_HZ = 250000000;
  localparam int MS_CYC = CLK_HZ / 1000;
  localparam int SLEEP_MIN = 16;
  localparam int SLEEP_MS = SLEEP_MIN * 60 * 1000;
  localparam int UPD_MS = 80;
  localparam int SPD_MS = 1000;
  // Error limits, in tenths of a display unit
  localparam logic [31:0] EARLY_MAX_SEC = 32'h00008C9F;
  localparam logic [31:0] EARLY_MAX_MIN = 32'h0000EA5F;
  localparam logic [31:0] LATE_MAX_SEC = 32'h0000176F;
  localparam logic [31:0] LATE_MAX_MIN = 32'h0000270F;
  localparam logic [31:0] TEN_ZONE = 32'h00000028;
  localparam logic [31:0] CDN_BASE = 32'h000186A0;
  // Format samples
  localparam logic [16:0] SMP_TEN = 17'h0000B;
  localparam logic [16:0] SMP_TEN_CDN = 17'h1869F;
  localparam logic [16:0] SMP_UNIT = 17'h0000A;
  localparam logic [16:0] SMP_UNIT_CDN = 17'h18696;

  typedef enum logic [2:0] {RDB_NUM, RDB_EEEE, RDB_LLLL, RDB_DASH, RDB_OFF} rdb_code_e;
  typedef enum logic [2:0] {AUX_EXT, AUX_SPLIT, AUX_DASH, AUX_LVL, AUX_OFF} rdb_aux_e;

  typedef struct packed {
    rdb_code_e code;
    logic [16:0] val;
    logic colon;
    logic dp;
    logic tenths;
    logic neg_l;
    logic neg_r;
  } rdb_disp_s;

  typedef struct packed {
    rdb_aux_e kind;
    rdb_disp_s err;
    logic [4:0] lvl_rem;
    logic [4:0] lvl_main;
  } rdb_aux_s;
endpackage

/* hw/rdb_ctrl.sv */
// Error readout formatting, brightness, blanking and remote refresh
`timescale 1ns/1ps
module rdb_ctrl
  import rdb_pkg::*;
#(
  parameter int unsigned MS_CYC_P = MS_CYC,
  parameter int unsigned SLEEP_MS_P = SLEEP_MS
)
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Operator switch pins
  input wire logic [3:0] rot_pos_i,
  input wire logic [1:0] aux_sel_i,
  input wire logic shift_i,
  input wire logic bri_up_i,
  input wire logic bri_dn_i,
  input wire logic fmt_up_i,
  input wire logic fmt_dn_i,
  input wire logic odo_pulse_i,
  // Timing core, times in 10 ms ticks
  input wire logic signed [31:0] calc_time_i,
  input wire logic signed [31:0] clock_time_i,
  input wire logic split_i,
  input wire logic aux_busy_i,
  input wire logic [15:0] speed_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Displays
  output rdb_disp_s err_disp_o,
  output rdb_aux_s aux_disp_o,
  output logic [4:0] main_lvl_o,
  output logic [4:0] rem_lvl_o,
  output logic blank_o,
  output logic rem_upd_o,
  output logic [15:0] rem_speed_o
);

  // Truncation toward zero keeps the readout one step ahead of the main displays
  function automatic rdb_disp_s fmt_err(input logic signed [31:0] dt, input logic [2:0] f);
    logic signed [31:0] tu;
    logic [31:0] mag;
    logic late;
    rdb_disp_s d;
    d = '0;
    tu = f[FMT_SEC] ? dt / 32'sd10 : dt / 32'sd6;
    late = tu < 32'sd0;
    mag = late ? 32'(-tu) : 32'(tu);
    d.colon = f[FMT_SEC];
    d.dp = ~f[FMT_SEC];
    d.code = RDB_NUM;
    if (late && mag > (f[FMT_SEC] ? LATE_MAX_SEC : LATE_MAX_MIN))
    begin
      d.code = RDB_LLLL;
    end
    else if (!late && mag > (f[FMT_SEC] ? EARLY_MAX_SEC : EARLY_MAX_MIN))
    begin
      d.code = RDB_EEEE;
    end
    d.tenths = f[FMT_TEN] && mag < TEN_ZONE;
    if (!d.tenths)
    begin
      mag = (mag / 32'd10) * 32'd10;
    end
    if (late && f[FMT_CDN])
    begin
      mag = CDN_BASE - mag;
    end
    else
    begin
      d.neg_l = late;
      d.neg_r = late && !f[FMT_TEN];
    end
    d.val = mag[16:0];
    return d;
  endfunction

  function automatic rdb_disp_s fmt_sample(input logic [2:0] f);
    rdb_disp_s d;
    d = '0;
    d.code = RDB_NUM;
    d.colon = f[FMT_SEC];
    d.dp = ~f[FMT_SEC];
    d.tenths = f[FMT_TEN];
    if (f[FMT_TEN])
    begin
      d.val = f[FMT_CDN] ? SMP_TEN_CDN : SMP_TEN;
    end
    else
    begin
      d.val = f[FMT_CDN] ? SMP_UNIT_CDN : SMP_UNIT;
    end
    return d;
  endfunction

  // Switch pins cross in through two flops; the third stage feeds edge detection
  logic [11:0] sw_raw;
  logic [11:0] sw1_r;
  logic [11:0] sw2_r;
  logic [11:0] sw3_r;
  assign sw_raw = {rot_pos_i, aux_sel_i, shift_i, bri_up_i, bri_dn_i, fmt_up_i, fmt_dn_i,
                   odo_pulse_i};

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      sw1_r <= '0;
      sw2_r <= '0;
      sw3_r <= '0;
    end
    else
    begin
      sw1_r <= sw_raw;
      sw2_r <= sw1_r;
      sw3_r <= sw2_r;
    end
  end

  logic [3:0] rot;
  logic [1:0] sel;
  logic shift;
  logic [5:0] rise;
  logic act;
  logic odo_p;
  logic special;
  logic next_spd;
  logic blank_r;
  logic live;
  logic bri_up;
  logic bri_dn;
  logic fmt_step;
  logic dim_off;
  logic [4:0] lvl_main_r;
  logic [4:0] lvl_rem_r;
  logic [2:0] fmt_r;
  logic adj_r;
  logic fmtsel_r;
  logic signed [31:0] dev;
  logic signed [31:0] frz_r;
  logic split_q_r;

  assign rot = sw2_r[11:8];
  assign sel = sw2_r[7:6];
  assign shift = sw2_r[5];
  assign rise = sw2_r[5:0] & ~sw3_r[5:0];
  assign act = (|rise[5:1]) | (sw2_r[11:6] != sw3_r[11:6]);
  assign odo_p = rise[0];
  assign special = rot == ROT_SPECIAL;
  assign next_spd = rot == ROT_NEXT_SPD;
  // Edges that wake a blank display are swallowed here
  assign live = ~blank_r;
  assign bri_up = live & special & rise[4];
  assign bri_dn = live & special & rise[3];
  assign fmt_step = live & special & shift & (rise[2] | rise[1]);
  assign dim_off = bri_dn & ~shift & (lvl_main_r == '0);
  assign dev = calc_time_i - clock_time_i;

  // Millisecond base and idle timer
  logic [31:0] ms_cnt_r;
  logic [31:0] sleep_cnt_r;
  logic [31:0] upd_cnt_r;
  logic [31:0] spd_cnt_r;
  logic ms_tick;
  logic sleep_hit;
  logic upd_tick;
  assign ms_tick = ms_cnt_r == 32'(MS_CYC_P - 1);
  assign sleep_hit = ms_tick & live & (sleep_cnt_r == 32'(SLEEP_MS_P - 1));
  assign upd_tick = ms_tick & (upd_cnt_r == 32'(UPD_MS - 1));

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i | ms_tick)
    begin
      ms_cnt_r <= '0;
    end
    else
    begin
      ms_cnt_r <= ms_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i | act | odo_p | next_spd | blank_r)
    begin
      sleep_cnt_r <= '0;
    end
    else if (ms_tick)
    begin
      sleep_cnt_r <= sleep_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      upd_cnt_r <= '0;
      spd_cnt_r <= '0;
    end
    else if (ms_tick)
    begin
      upd_cnt_r <= upd_tick ? 32'h0 : upd_cnt_r + 32'h1;
      spd_cnt_r <= (spd_cnt_r == 32'(SPD_MS - 1)) ? 32'h0 : spd_cnt_r + 32'h1;
    end
  end

  // Blanking: wake has priority so the waking edge never re-blanks
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      blank_r <= 1'b0;
    end
    else if (blank_r & (act | odo_p))
    begin
      blank_r <= 1'b0;
    end
    else if (dim_off | sleep_hit)
    begin
      blank_r <= 1'b1;
    end
  end

  // Levels saturate at both ends; only the main group blanks at the bottom
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      lvl_main_r <= LVL_RST;
      lvl_rem_r <= LVL_RST;
    end
    else if (bri_up & shift & (lvl_rem_r != LVL_MAX))
    begin
      lvl_rem_r <= lvl_rem_r + 5'h1;
    end
    else if (bri_dn & shift & (lvl_rem_r != '0))
    begin
      lvl_rem_r <= lvl_rem_r - 5'h1;
    end
    else if (bri_up & ~shift & (lvl_main_r != LVL_MAX))
    begin
      lvl_main_r <= lvl_main_r + 5'h1;
    end
    else if (bri_dn & ~shift & (lvl_main_r != '0))
    begin
      lvl_main_r <= lvl_main_r - 5'h1;
    end
  end

  // Adjust and select modes end when the rotary leaves the special position
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i | ~special)
    begin
      adj_r <= 1'b0;
      fmtsel_r <= 1'b0;
    end
    else
    begin
      if (bri_up | bri_dn)
      begin
        adj_r <= 1'b1;
      end
      else if (fmt_step)
      begin
        adj_r <= 1'b0;
      end
      if (fmt_step)
      begin
        fmtsel_r <= 1'b1;
      end
      else if (~shift)
      begin
        fmtsel_r <= 1'b0;
      end
    end
  end

  // Three format bits step through all eight combinations
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      fmt_r <= FMT_RST;
    end
    else if (fmt_step)
    begin
      fmt_r <= fmt_r + 3'h1;
    end
    else if (wr_i && addr_i == REG_FMT)
    begin
      fmt_r <= wdata_i[2:0];
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      split_q_r <= 1'b0;
      frz_r <= '0;
    end
    else
    begin
      split_q_r <= split_i;
      if (split_i & ~split_q_r)
      begin
        frz_r <= dev;
      end
    end
  end

  // Remote readouts follow the live error, never the frozen one
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      err_disp_o <= '0;
      rem_upd_o <= 1'b0;
      rem_speed_o <= '0;
    end
    else
    begin
      rem_upd_o <= upd_tick;
      if (blank_r)
      begin
        err_disp_o.code <= RDB_OFF;
      end
      else if (upd_tick)
      begin
        err_disp_o <= fmtsel_r ? fmt_sample(fmt_r) : fmt_err(dev, fmt_r);
      end
      if (ms_tick && spd_cnt_r == 32'(SPD_MS - 1))
      begin
        rem_speed_o <= speed_i;
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      aux_disp_o <= '0;
    end
    else
    begin
      aux_disp_o.err <= fmt_err(frz_r, fmt_r);
      aux_disp_o.lvl_main <= lvl_main_r;
      aux_disp_o.lvl_rem <= lvl_rem_r;
      if (blank_r)
      begin
        aux_disp_o.kind <= AUX_OFF;
      end
      else if (adj_r)
      begin
        aux_disp_o.kind <= AUX_LVL;
      end
      else if (sel == SEL_DELTA && next_spd && split_i)
      begin
        aux_disp_o.kind <= AUX_SPLIT;
      end
      else if (sel == SEL_DELTA && !next_spd && !aux_busy_i)
      begin
        aux_disp_o.kind <= AUX_DASH;
      end
      else
      begin
        aux_disp_o.kind <= AUX_EXT;
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i | ~rd_i)
    begin
      rdata_o <= '0;
    end
    else
    begin
      case (addr_i)
        REG_FMT: rdata_o <= {29'h0, fmt_r};
        REG_LVL: rdata_o <= {21'h0, blank_r, lvl_rem_r, lvl_main_r};
        REG_ERR: rdata_o <= {12'h0, err_disp_o.code, err_disp_o.val};
        default: rdata_o <= '0;
      endcase
    end
  end

  assign main_lvl_o = lvl_main_r;
  assign rem_lvl_o = lvl_rem_r;
  assign blank_o = blank_r;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_wake_req;
    blank_r && act;
  endsequence
  sequence s_wake_done;
    !blank_r && $stable(lvl_main_r) && $stable(lvl_rem_r) && $stable(fmt_r);
  endsequence

  property p_wake;
    s_wake_req |=> s_wake_done;
  endproperty
  a_wake: assert property (p_wake) else $error("wake edge changed a value");

  property p_dim_off;
    special && rise[3] && !shift && !blank_r && lvl_main_r == '0 |=> blank_r ##1 blank_o;
  endproperty
  a_dim_off: assert property (p_dim_off) else $error("dim below lowest did not blank");

  property p_lvl_up;
    bri_up && !shift && lvl_main_r != LVL_MAX |=> lvl_main_r == $past(lvl_main_r) + 5'h1;
  endproperty
  a_lvl_up: assert property (p_lvl_up) else $error("main level did not rise by one");

  property p_rem_up;
    bri_up && shift |=> lvl_main_r == $past(lvl_main_r);
  endproperty
  a_rem_up: assert property (p_rem_up) else $error("shifted step touched main level");

  property p_fmt;
    fmt_step |=> fmt_r == $past(fmt_r) + 3'h1 ##1 fmtsel_r || !special;
  endproperty
  a_fmt: assert property (p_fmt) else $error("format did not advance");

  property p_nosleep;
    next_spd |=> sleep_cnt_r == '0 && !sleep_hit;
  endproperty
  a_nosleep: assert property (p_nosleep) else $error("idle timer ran at next speed");

  property p_dash;
    sel == SEL_DELTA && !next_spd && !aux_busy_i && !adj_r && !blank_r
      |=> aux_disp_o.kind == AUX_DASH;
  endproperty
  a_dash: assert property (p_dash) else $error("dashes not shown");

  property p_live;
    upd_tick && !fmtsel_r && !blank_r
      |=> rem_upd_o && err_disp_o == fmt_err($past(dev), $past(fmt_r));
  endproperty
  a_live: assert property (p_live) else $error("remote error not live");

endmodule

/* tb/rdb_remote_model.sv */
// Driver's remote module model: latches each refresh and times the gap
`timescale 1ns/1ps
module rdb_remote_model
  import rdb_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Refresh link from the controller
  input wire logic rem_upd_i,
  input wire rdb_disp_s err_i,
  input wire logic [15:0] speed_i,
  // What the driver sees
  output rdb_disp_s shown_err_o,
  output logic [15:0] shown_speed_o,
  output int upd_cnt_o,
  output int gap_o
);
  int since_r;

  // Digits change only on a refresh pulse, as the real module latches them
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      shown_err_o <= '0;
      shown_speed_o <= 16'h0;
      upd_cnt_o <= 0;
      gap_o <= 0;
      since_r <= 0;
    end
    else if (rem_upd_i)
    begin
      shown_err_o <= err_i;
      shown_speed_o <= speed_i;
      upd_cnt_o <= upd_cnt_o + 1;
      gap_o <= since_r + 1;
      since_r <= 0;
    end
    else
    begin
      since_r <= since_r + 1;
    end
  end
endmodule

/* tb/rdb_ctrl_bench.sv */
// Self-checking bench for the error display and brightness controller
`timescale 1ns/1ps
module rdb_ctrl_bench;
  import rdb_pkg::*;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic [3:0] rot = ROT_NEXT_SPD;
  logic [1:0] asel = 2'h0;
  logic shift = 1'h0;
  logic odo = 1'h0;
  logic split = 1'h0;
  logic busy = 1'h0;
  logic [15:0] spd_in = 16'h1234;
  logic [3:0] sw = 4'h0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic signed [31:0] calc = 32'sh100000;
  logic signed [31:0] clk_t = 32'sh100000;
  logic [31:0] rdata;
  logic [31:0] rv;
  rdb_disp_s err;
  rdb_disp_s shown;
  rdb_aux_s aux;
  logic [4:0] mlvl;
  logic [4:0] rlvl;
  logic blank;
  logic upd;
  logic [15:0] spd;
  logic [15:0] shown_spd;
  logic [2:0] f;
  int cnt;
  int gap;
  int miscompares = 0;
  int n_checks = 0;

  // Short ms tick and a 200 ms sleep keep the run brief but above one refresh
  rdb_ctrl #(.MS_CYC_P(4), .SLEEP_MS_P(200)) i_dut (
    .mclk_i(mclk), .sys_rst_i(rst), .rot_pos_i(rot), .aux_sel_i(asel),
    .shift_i(shift), .bri_up_i(sw[0]), .bri_dn_i(sw[1]), .fmt_up_i(sw[2]),
    .fmt_dn_i(sw[3]), .odo_pulse_i(odo), .calc_time_i(calc), .clock_time_i(clk_t),
    .split_i(split), .aux_busy_i(busy), .speed_i(spd_in), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .err_disp_o(err),
    .aux_disp_o(aux), .main_lvl_o(mlvl), .rem_lvl_o(rlvl), .blank_o(blank),
    .rem_upd_o(upd), .rem_speed_o(spd));

  rdb_remote_model p (.mclk_i(mclk), .sys_rst_i(rst), .rem_upd_i(upd),
    .err_i(err), .speed_i(spd), .shown_err_o(shown), .shown_speed_o(shown_spd),
    .upd_cnt_o(cnt), .gap_o(gap));

  initial
  begin
    forever #2 mclk = ~mclk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chkd(input rdb_disp_s e, input rdb_disp_s g);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error display expected %h seen %h", e, g);
    end
  endtask

  task automatic wrr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge mclk);
    wr <= 1'h0;
  endtask

  task automatic rdr(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'h1;
    @(posedge mclk);
    rd <= 1'h0;
    @(posedge mclk);
    d = rdata;
  endtask

  // Toggle actuation; the trailing wait covers the synchroniser delay
  task automatic tog(input int k);
    @(posedge mclk);
    sw[k] <= 1'h1;
    cyc(3);
    sw[k] <= 1'h0;
    cyc(8);
  endtask

  task automatic odo_p();
    odo <= 1'h1;
    cyc(3);
    odo <= 1'h0;
    cyc(8);
  endtask

  task automatic wu(input int n);
    int t;
    t = cnt + n;
    for (int i = 0; i < 2000 && cnt < t; i++)
      @(posedge mclk);
    if (cnt < t)
    begin
      miscompares++;
      $display("Error refresh count expected %0d seen %0d", t, cnt);
    end
  endtask

  // Flags in f: colon, point, tenths, left minus, right minus
  function automatic rdb_disp_s mk(input rdb_code_e c, input int v, input logic [4:0] f);
    mk = '{c, v[16:0], f[4], f[3], f[2], f[1], f[0]};
  endfunction

  task automatic ecase(input logic [2:0] fm, input int d, input rdb_disp_s e);
    wrr(REG_FMT, {29'h0, fm});
    calc <= 32'sh100000 + d;
    wu(2);
    if (e.code == RDB_NUM)
      chkd(e, shown);
    else
      chk("error code", {29'h0, e.code}, {29'h0, shown.code});
  endtask

  task automatic end_sim();
    $display("Checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    cyc(60000);
    miscompares++;
    end_sim();
  end

  initial
  begin
    cyc(3);
    rst <= 1'h0;
    rdr(REG_LVL, rv);
    chk("level reg", 32'h3FF, rv);
    rdr(REG_FMT, rv);
    chk("format reg", 32'h0, rv);
    rdr(4'hC, rv);
    chk("unmapped", 32'h0, rv);
    $display("Test reset done");

    rot <= ROT_SPECIAL;
    tog(1);
    chk("main level", 32'h1E, {27'h0, mlvl});
    chk("aux kind", {29'h0, AUX_LVL}, {29'h0, aux.kind});
    chk("aux levels", 32'h3FE, {22'h0, aux.lvl_rem, aux.lvl_main});
    shift <= 1'h1;
    tog(1);
    shift <= 1'h0;
    chk("remote level", 32'h1E, {27'h0, rlvl});
    tog(0);
    tog(0);
    chk("main sat", 32'h1F, {27'h0, mlvl});
    rdr(REG_LVL, rv);
    chk("level reg", 32'h3DF, rv);
    $display("Test brightness done");

    wrr(REG_FMT, 32'h3);
    rdr(REG_FMT, rv);
    chk("format reg", 32'h3, rv);
    shift <= 1'h1;
    for (int k = 4; k < 11; k++)
    begin
      tog(2 + k % 2);
      wu(1);
      f = k[2:0];
      rdr(REG_FMT, rv);
      chk("format step", {29'h0, f}, rv);
      chk("sample", {15'h0, f[2] ? (f[1] ? SMP_TEN_CDN : SMP_TEN)
        : (f[1] ? SMP_UNIT_CDN : SMP_UNIT)}, {15'h0, shown.val});
    end
    shift <= 1'h0;
    $display("Test format done");

    repeat (31) tog(1);
    chk("main floor", 32'h0, {27'h0, mlvl});
    tog(1);
    chk("blank", 32'h1, {31'h0, blank});
    chk("blank code", {29'h0, RDB_OFF}, {29'h0, err.code});
    tog(0);
    chk("wake", 32'h0, {31'h0, blank});
    chk("wake level", 32'h0, {27'h0, mlvl});
    $display("Test blanking done");

    rot <= 4'h3;
    cyc(900);
    chk("sleep", 32'h1, {31'h0, blank});
    odo_p();
    chk("odo wake", 32'h0, {31'h0, blank});
    repeat (3)
    begin
      cyc(500);
      chk("idle restart", 32'h0, {31'h0, blank});
      odo_p();
    end
    rot <= ROT_NEXT_SPD;
    cyc(1000);
    chk("no sleep", 32'h0, {31'h0, blank});
    $display("Test sleep done");

    ecase(3'h1, 500, mk(RDB_NUM, 50, 5'h10));
    rdr(REG_ERR, rv);
    chk("error reg", 32'h32, rv);
    asel <= SEL_DELTA;
    rot <= 4'h3;
    cyc(8);
    chk("aux dash", {29'h0, AUX_DASH}, {29'h0, aux.kind});
    busy <= 1'h1;
    cyc(8);
    chk("aux busy", {29'h0, AUX_EXT}, {29'h0, aux.kind});
    busy <= 1'h0;
    rot <= ROT_NEXT_SPD;
    split <= 1'h1;
    cyc(8);
    chk("aux split", {29'h0, AUX_SPLIT}, {29'h0, aux.kind});
    calc <= 32'sh100000 + 700;
    wu(2);
    chk("live error", 32'h46, {15'h0, shown.val});
    chk("frozen error", 32'h32, {15'h0, aux.err.val});
    split <= 1'h0;
    asel <= 2'h0;
    $display("Test split done");

    ecase(3'h1, -500, mk(RDB_NUM, 50, 5'h13));
    ecase(3'h5, -390, mk(RDB_NUM, 39, 5'h16));
    ecase(3'h5, 400, mk(RDB_NUM, 40, 5'h10));
    ecase(3'h3, -100, mk(RDB_NUM, 99990, 5'h10));
    ecase(3'h0, 6000, mk(RDB_NUM, 1000, 5'h08));
    ecase(3'h1, 360000, mk(RDB_EEEE, 0, 5'h00));
    ecase(3'h1, -60100, mk(RDB_LLLL, 0, 5'h00));
    chk("refresh gap", 32'd320, gap);
    spd_in <= 16'h5678;
    for (int i = 0; i < 5000 && shown_spd != 16'h5678; i++)
      @(posedge mclk);
    chk("speed", 32'h5678, {16'h0, shown_spd});
    // Two fast refreshes pass long before the next one-second speed latch
    spd_in <= 16'h9ABC;
    wu(2);
    chk("speed hold", 32'h5678, {16'h0, shown_spd});
    for (int i = 0; i < 5000 && shown_spd != 16'h9ABC; i++)
      @(posedge mclk);
    chk("speed next", 32'h9ABC, {16'h0, shown_spd});
    $display("Test error display done");
    end_sim();
  end
endmodule
